// ---- bpms_pkg.sv ----
package bpms_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned EXEMPT_S = 30;
  localparam logic [31:0] EXEMPT_CYC = 32'(EXEMPT_S * CLK_HZ);
  localparam int unsigned RA_W = 3;
  localparam logic [RA_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [RA_W-1:0] OFS_CMD = 3'h1;
  localparam logic [RA_W-1:0] OFS_MAXMISS = 3'h2;
  localparam logic [RA_W-1:0] OFS_TURN = 3'h3;
  localparam logic [RA_W-1:0] OFS_PADDR = 3'h4;
  localparam logic [RA_W-1:0] OFS_PARAM = 3'h5;
  localparam logic [RA_W-1:0] OFS_STATUS = 3'h6;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_PRIM = 1;
  localparam int unsigned CTRL_INIT = 2;
  localparam int unsigned CTRL_PROMOTE = 3;
  localparam int unsigned CTRL_AUTO = 4;
  localparam int unsigned CMD_RTS = 0;
  localparam int unsigned CMD_CEASE = 1;
  localparam int unsigned CMD_CLR = 2;
  localparam int unsigned ST_LOST = 0;
  localparam int unsigned ST_NACK = 1;
  localparam int unsigned ST_ACK = 2;
  localparam int unsigned ST_PROM = 3;
  localparam int unsigned ST_FSM = 4;
  localparam int unsigned ST_MISS = 8;
  localparam logic [7:0] MAXMISS_RST = 8'h04;
  localparam logic [15:0] TURN_RST = 16'h0004;
  typedef enum logic [2:0] {
    BP_IDLE   = 3'h0,
    BP_SYNC   = 3'h1,
    BP_BEACON = 3'h3,
    BP_GAP1   = 3'h2,
    BP_LISTEN = 3'h6,
    BP_GAP2   = 3'h7,
    BP_ANSWER = 3'h5
  } bpms_state_e;
endpackage

// ---- bpms_top.sv ----
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
module bpms_top #(
  parameter int unsigned AW = 16,
  parameter int unsigned PW = 16,
  parameter logic [31:0] EXEMPT = bpms_pkg::EXEMPT_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic [bpms_pkg::RA_W-1:0] reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  input  wire logic                    reg_we_i,
  input  wire logic                    reg_re_i,
  output logic      [15:0]             reg_rdata_o,
  input  wire logic                    sync_done_i,
  input  wire logic                    slot_end_i,
  input  wire logic                    tx_done_i,
  input  wire logic                    rts_det_i,
  input  wire logic                    ack_rx_i,
  input  wire logic                    nack_rx_i,
  input  wire logic                    rx_beacon_i,
  input  wire logic [AW-1:0]           rx_src_addr_i,
  input  wire logic [PW-1:0]           rx_param_i,
  output logic                         tx_beacon_o,
  output logic                         tx_rts_o,
  output logic                         tx_ack_o,
  output logic                         tx_nack_o,
  output logic                         rx_en_o,
  output logic                         beacon_cease_o,
  output logic                         init_bit_o,
  output logic      [PW-1:0]           beacon_param_o,
  output logic                         incoming_beacon_indication_o,
  output logic                         beacon_lost_indication_o,
  output logic                         start_nack_o
);
  typedef struct packed {
    bpms_pkg::bpms_state_e st;
    logic [15:0]   gap;
    logic [7:0]    miss;
    logic          en;
    logic          prim;
    logic          init;
    logic          autor;
    logic          prom;
    logic [31:0]   exempt;
    logic [7:0]    maxmiss;
    logic [15:0]   turn;
    logic [AW-1:0] paddr;
    logic [PW-1:0] param;
    logic          rts_pend;
    logic          rts_sent;
    logic          rts_seen;
    logic          granted;
    logic          txmode;
    logic          cease_pend;
    logic          lost;
    logic          nackf;
    logic          ackf;
    logic [15:0]   rdata;
    logic          tx_beacon;
    logic          tx_rts;
    logic          tx_ack;
    logic          tx_nack;
    logic          rx_en;
    logic          cease;
    logic          ind_in;
    logic          ind_lost;
    logic          snack;
  } bpms_s;

  bpms_s q;
  bpms_s d;

  function automatic logic wr(input logic [bpms_pkg::RA_W-1:0] a);
    wr = reg_we_i && (reg_addr_i == a);
  endfunction

  always_comb
  begin
    d = q;
    d.tx_beacon = 1'b0;
    d.tx_rts = 1'b0;
    d.tx_ack = 1'b0;
    d.tx_nack = 1'b0;
    d.ind_in = 1'b0;
    d.ind_lost = 1'b0;
    d.snack = 1'b0;
    d.rdata = 16'h0000;
    if (q.exempt != 32'h0000_0000)
      d.exempt = q.exempt - 32'h0000_0001;
    if (wr(bpms_pkg::OFS_CTRL))
    begin
      d.en = reg_wdata_i[bpms_pkg::CTRL_EN];
      d.prim = reg_wdata_i[bpms_pkg::CTRL_PRIM];
      d.init = reg_wdata_i[bpms_pkg::CTRL_INIT];
      d.autor = reg_wdata_i[bpms_pkg::CTRL_AUTO];
      if (reg_wdata_i[bpms_pkg::CTRL_PROMOTE])
      begin
        d.prim = 1'b1;
        d.prom = 1'b1;
        d.exempt = EXEMPT;
      end
    end
    if (wr(bpms_pkg::OFS_MAXMISS))
      d.maxmiss = reg_wdata_i[7:0];
    if (wr(bpms_pkg::OFS_TURN))
      d.turn = reg_wdata_i;
    if (wr(bpms_pkg::OFS_PADDR))
      d.paddr = reg_wdata_i[AW-1:0];
    if (wr(bpms_pkg::OFS_PARAM))
      d.param = reg_wdata_i[PW-1:0];
    if (wr(bpms_pkg::OFS_CMD))
    begin
      if (reg_wdata_i[bpms_pkg::CMD_RTS] || reg_wdata_i[bpms_pkg::CMD_CEASE])
        d.rts_pend = ~q.prim;
      if (reg_wdata_i[bpms_pkg::CMD_CEASE])
        d.cease_pend = 1'b1;
      if (reg_wdata_i[bpms_pkg::CMD_CLR])
      begin
        d.lost = 1'b0;
        d.nackf = 1'b0;
        d.ackf = 1'b0;
      end
    end
    if (reg_re_i)
    begin
      case (reg_addr_i)
        bpms_pkg::OFS_CTRL:
          d.rdata = 16'({q.autor, 1'b0, q.init, q.prim, q.en});
        bpms_pkg::OFS_MAXMISS: d.rdata = 16'(q.maxmiss);
        bpms_pkg::OFS_TURN: d.rdata = q.turn;
        bpms_pkg::OFS_PADDR: d.rdata = 16'(q.paddr);
        bpms_pkg::OFS_PARAM: d.rdata = 16'(q.param);
        bpms_pkg::OFS_STATUS:
          d.rdata = {q.miss, 1'b0, q.st, q.prom, q.ackf, q.nackf, q.lost};
        default: d.rdata = 16'h0000;
      endcase
    end
    if (rx_beacon_i && q.rx_en && q.st == bpms_pkg::BP_BEACON)
    begin
      d.ind_in = 1'b1;
      if (!q.prim)
      begin
        d.miss = 8'h00;
        d.param = rx_param_i;
        if (rx_src_addr_i != q.paddr)
        begin
          d.paddr = rx_src_addr_i;
          if (q.autor)
            d.rts_pend = 1'b1;
        end
      end
    end
    case (q.st)
      bpms_pkg::BP_IDLE:
      begin
        d.rx_en = 1'b0;
        d.cease = 1'b0;
        if (q.en)
          d.st = bpms_pkg::BP_SYNC;
      end
      bpms_pkg::BP_SYNC:
      begin
        d.rts_seen = 1'b0;
        d.rts_sent = 1'b0;
        if (!q.en)
          d.st = bpms_pkg::BP_IDLE;
        else if (sync_done_i)
        begin
          d.st = bpms_pkg::BP_BEACON;
          d.txmode = q.prim ? ~q.granted : q.granted;
          d.tx_beacon = d.txmode;
          d.rx_en = ~d.txmode;
          d.cease = d.txmode && d.cease_pend;
        end
      end
      bpms_pkg::BP_BEACON:
      begin
        if (q.txmode && tx_done_i)
        begin
          d.granted = 1'b0;
          d.cease = 1'b0;
          if (q.cease)
          begin
            d.en = 1'b0;
            d.cease_pend = 1'b0;
            d.st = bpms_pkg::BP_IDLE;
          end
          else
          begin
            d.st = bpms_pkg::BP_GAP1;
            d.gap = q.turn;
          end
        end
        else if (!q.txmode && (rx_beacon_i || slot_end_i))
        begin
          d.granted = 1'b0;
          d.st = bpms_pkg::BP_GAP1;
          d.gap = q.turn;
          if (!q.prim && !rx_beacon_i)
          begin
            if (q.miss != 8'hff)
              d.miss = q.miss + 8'h01;
            if (q.miss + 8'h01 == q.maxmiss)
            begin
              d.ind_lost = 1'b1;
              d.lost = 1'b1;
            end
          end
        end
      end
      bpms_pkg::BP_GAP1:
      begin
        if (q.gap == 16'h0000)
        begin
          d.st = bpms_pkg::BP_LISTEN;
          d.rx_en = q.prim;
          if (!q.prim && q.rts_pend)
          begin
            d.tx_rts = 1'b1;
            d.rts_sent = 1'b1;
            d.rts_pend = 1'b0;
          end
        end
        else
          d.gap = q.gap - 16'h0001;
      end
      bpms_pkg::BP_LISTEN:
      begin
        if (q.prim && rts_det_i)
          d.rts_seen = 1'b1;
        if (slot_end_i)
        begin
          d.st = bpms_pkg::BP_GAP2;
          d.gap = q.turn;
          d.rx_en = 1'b0;
        end
      end
      bpms_pkg::BP_GAP2:
      begin
        if (q.gap == 16'h0000)
        begin
          d.st = bpms_pkg::BP_ANSWER;
          d.rx_en = ~q.prim & q.rts_sent;
          d.tx_ack = q.prim & q.rts_seen;
          d.tx_nack = q.prim & ~q.rts_seen;
        end
        else
          d.gap = q.gap - 16'h0001;
      end
      bpms_pkg::BP_ANSWER:
      begin
        if (q.prim)
        begin
          if (tx_done_i)
          begin
            d.st = bpms_pkg::BP_SYNC;
            d.granted = q.rts_seen;
          end
        end
        else if (!q.rts_sent)
          d.st = bpms_pkg::BP_SYNC;
        else if (ack_rx_i)
        begin
          d.st = bpms_pkg::BP_SYNC;
          d.rx_en = 1'b1;
          d.granted = 1'b1;
          d.ackf = 1'b1;
        end
        else if (nack_rx_i || slot_end_i)
        begin
          d.st = bpms_pkg::BP_SYNC;
          d.rx_en = 1'b1;
          d.snack = 1'b1;
          d.nackf = 1'b1;
          d.cease_pend = 1'b0;
        end
      end
      default: d.st = bpms_pkg::BP_IDLE;
    endcase
    // Secondary keeps its receiver on while it waits in SYNC
    if (q.st == bpms_pkg::BP_SYNC && !q.prim && d.st != bpms_pkg::BP_BEACON)
      d.rx_en = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.st <= bpms_pkg::BP_IDLE;
      q.maxmiss <= bpms_pkg::MAXMISS_RST;
      q.turn <= bpms_pkg::TURN_RST;
    end
    else
      q <= d;
  end

  assign reg_rdata_o = q.rdata;
  assign tx_beacon_o = q.tx_beacon;
  assign tx_rts_o = q.tx_rts;
  assign tx_ack_o = q.tx_ack;
  assign tx_nack_o = q.tx_nack;
  assign rx_en_o = q.rx_en;
  assign beacon_cease_o = q.cease;
  assign init_bit_o = q.init & q.prim & (q.exempt == 32'h0000_0000);
  assign beacon_param_o = q.param;
  assign incoming_beacon_indication_o = q.ind_in;
  assign beacon_lost_indication_o = q.ind_lost;
  assign start_nack_o = q.snack;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_gap2_done;
    q.st == bpms_pkg::BP_GAP2 && q.gap == 16'h0000;
  endsequence

  sequence s_gap1_done;
    q.st == bpms_pkg::BP_GAP1 && q.gap == 16'h0000;
  endsequence

  a_ack_on_rts: assert property (
    (s_gap2_done and (q.prim && q.rts_seen)) |=> tx_ack_o && !tx_nack_o)
    else $error("ack missing after request");
  a_nack_no_rts: assert property (
    (s_gap2_done and (q.prim && !q.rts_seen)) |=> tx_nack_o && !tx_ack_o)
    else $error("nack missing without request");
  a_ack_nack_excl: assert property (
    !(tx_ack_o && tx_nack_o))
    else $error("ack and nack together");
  a_beacon_grant: assert property (
    q.st == bpms_pkg::BP_SYNC && sync_done_i && q.en && q.prim
    |=> tx_beacon_o == !$past(q.granted))
    else $error("primary beacon decision wrong");
  a_grant_listen: assert property (
    q.st == bpms_pkg::BP_SYNC && sync_done_i && q.en && q.prim && q.granted
    |=> rx_en_o && !tx_beacon_o)
    else $error("granted slot not heard");
  a_in_ind: assert property (
    rx_beacon_i && rx_en_o && q.st == bpms_pkg::BP_BEACON
    |=> incoming_beacon_indication_o)
    else $error("beacon not indicated");
  a_lost_ind: assert property (
    beacon_lost_indication_o |-> q.miss == q.maxmiss && q.lost)
    else $error("lost indicated at wrong count");
  a_cease_tx: assert property (
    tx_beacon_o && q.cease_pend |-> beacon_cease_o)
    else $error("final beacon lacks cease");
  a_exempt: assert property (
    q.exempt != 32'h0000_0000 |-> !init_bit_o)
    else $error("init bit during exemption");
  a_addr_follow: assert property (
    rx_beacon_i && rx_en_o && !q.prim && q.st == bpms_pkg::BP_BEACON
    |=> q.paddr == $past(rx_src_addr_i))
    else $error("primary address not updated");
  a_refresh_req: assert property (
    rx_beacon_i && rx_en_o && !q.prim && q.autor
    && q.st == bpms_pkg::BP_BEACON && rx_src_addr_i != q.paddr
    |=> q.rts_pend)
    else $error("refresh request missing");
  a_nack_nobcn: assert property (
    start_nack_o |-> !q.granted ##1 !tx_beacon_o)
    else $error("beacon sent after nack");
  a_gap_len: assert property (
    $rose(q.st == bpms_pkg::BP_GAP1) && q.turn == 16'h0004
    |-> (q.st == bpms_pkg::BP_GAP1) [*5] ##1 q.st == bpms_pkg::BP_LISTEN)
    else $error("turnaround gap length wrong");
  a_listen_next: assert property (
    s_gap1_done |=> q.st == bpms_pkg::BP_LISTEN)
    else $error("listen does not follow gap");
  a_miss_clr: assert property (
    rx_beacon_i && rx_en_o && !q.prim && q.st == bpms_pkg::BP_BEACON
    |=> q.miss == 8'h00)
    else $error("miss count not cleared");
endmodule

// ---- bpms_peer.sv ----
`timescale 1ns/100ps
module bpms_peer (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic tx_any_i,
  input  wire logic tx_rts_i,
  input  wire logic rx_en_i,
  input  wire logic rts_on_i,
  input  wire logic ans_ack_i,
  output logic      tx_done_o,
  output logic      rts_det_o,
  output logic      ack_rx_o,
  output logic      nack_rx_o
);
  logic [1:0] dly_q;
  logic       en_q;
  logic [5:0] hold_q;
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {dly_q, en_q, hold_q, tx_done_o, rts_det_o, ack_rx_o, nack_rx_o} <= '0;
    else
    begin
      dly_q     <= {dly_q[0], tx_any_i};
      tx_done_o <= dly_q[1];
      en_q      <= rx_en_i;
      rts_det_o <= rts_on_i & rx_en_i & ~en_q;
      // Held so the answer slot always sees it
      hold_q    <= tx_rts_i ? 6'h28 : hold_q - 6'(hold_q != 6'h00);
      ack_rx_o  <= (hold_q != 6'h00) & ans_ack_i;
      nack_rx_o <= (hold_q != 6'h00) & ~ans_ack_i;
    end
  end
endmodule

// ---- test_beacon_protector_mac_sequencer.sv ----
`timescale 1ns/100ps
module test_beacon_protector_mac_sequencer;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [2:0]  ra = 3'h0;
  logic [15:0] wd = 16'h0000;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [2:0]  lk = 3'h0;
  logic [15:0] src = 16'h0000;
  logic [15:0] prm = 16'h0000;
  logic        rts_on = 1'b0;
  logic        ans_ack = 1'b0;
  logic [15:0] rdo;
  logic [15:0] bp;
  logic        tdn, rdet, ackr, nakr, bcn, trt, tak, tnk;
  logic        rxe, cs, ini, inc, lst, snk;
  logic [7:0]  ev;
  logic [7:0]  expq[$];
  logic [15:0] pa;
  logic [15:0] pp;
  int          errors = 0;
  int          check_count = 0;

  always #10 clk_i = ~clk_i;

  bpms_top #(.EXEMPT(32'h14)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdo), .sync_done_i(lk[0]),
    .slot_end_i(lk[1]), .tx_done_i(tdn), .rts_det_i(rdet), .ack_rx_i(ackr),
    .nack_rx_i(nakr), .rx_beacon_i(lk[2]), .rx_src_addr_i(src),
    .rx_param_i(prm), .tx_beacon_o(bcn), .tx_rts_o(trt), .tx_ack_o(tak),
    .tx_nack_o(tnk), .rx_en_o(rxe), .beacon_cease_o(cs), .init_bit_o(ini),
    .beacon_param_o(bp), .incoming_beacon_indication_o(inc),
    .beacon_lost_indication_o(lst), .start_nack_o(snk));

  bpms_peer PEER (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .tx_any_i(bcn | tak | tnk | trt),
    .tx_rts_i(trt), .rx_en_i(rxe), .rts_on_i(rts_on), .ans_ack_i(ans_ack),
    .tx_done_o(tdn), .rts_det_o(rdet), .ack_rx_o(ackr), .nack_rx_o(nakr));

  task final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task tmo();
    chk(16'h0000, 16'h0001);
    final_report();
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task rdc(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_i);
    re <= 1'b1;
    ra <= a;
    @(posedge clk_i);
    re <= 1'b0;
    @(negedge clk_i);
    chk(e, rdo & m);
  endtask

  task pulse(input int k);
    @(posedge clk_i);
    lk[k] <= 1'b1;
    @(posedge clk_i);
    lk[k] <= 1'b0;
  endtask

  task rxb(input logic [15:0] a, input logic [15:0] p);
    @(posedge clk_i);
    lk[2] <= 1'b1;
    src <= a;
    prm <= p;
    // Stale fields must not look valid
    @(posedge clk_i);
    lk[2] <= 1'b0;
    src <= ~a;
    prm <= ~p;
  endtask

  task wait_q();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 300)
      tmo();
    cyc(3);
  endtask

  task prim_sf(input logic r, input logic gr);
    int n;
    n = 0;
    rts_on <= r;
    expq.push_back(gr ? 8'h10 : 8'h01);
    expq.push_back(r ? 8'h02 : 8'h04);
    pulse(0);
    if (gr)
    begin
      cyc(1);
      @(negedge clk_i);
      chk(1, rxe);
      rxb(pa, pp);
    end
    while (!gr && tdn !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n == 50)
      tmo();
    n = 0;
    while (rxe !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n == 50)
      tmo();
    if (!gr)
      chk(1, n >= 5 && n <= 8);
    cyc(8);
    pulse(1);
    wait_q();
    rts_on <= 1'b0;
  endtask

  task sec_sf(input logic b, input logic [15:0] ex);
    if (b)
      expq.push_back(8'h10);
    if (ex[7:0] != 8'h00)
      expq.push_back(ex[7:0]);
    if (ex[15:8] != 8'h00)
      expq.push_back(ex[15:8]);
    pulse(0);
    cyc(2);
    if (b)
      rxb(pa, pp);
    else
      pulse(1);
    // Slot ends outside their state are ignored
    repeat (4)
    begin
      cyc(12);
      pulse(1);
    end
    wait_q();
  endtask

  // Mid-cycle look, outputs long settled
  always @(negedge clk_i)
  begin
    ev = {cs & bcn, snk, lst, inc, trt, tnk, tak, bcn};
    if (rst_b_i === 1'b1 && ev !== 8'h00)
    begin
      if (expq.size() == 0)
        chk(0, ev);
      else
        chk(expq.pop_front(), ev);
    end
  end

  initial
  begin
    void'($urandom(32'h6c37));
    cyc(5);
    rst_b_i <= 1'b1;
    rdc(bpms_pkg::OFS_MAXMISS, 16'hffff, 16'h0004);
    rdc(bpms_pkg::OFS_TURN, 16'hffff, 16'h0004);
    wr(3'h7, 16'h5a5a);
    rdc(3'h7, 16'hffff, 16'h0000);
    rdc(bpms_pkg::OFS_STATUS, 16'hffff, 16'h0000);
    $display("reset test done");
    pp = 16'($urandom);
    wr(bpms_pkg::OFS_PARAM, pp);
    wr(bpms_pkg::OFS_CTRL, 16'h0003);
    cyc(2);
    chk(pp, bp);
    prim_sf(1'b0, 1'b0);
    prim_sf(1'b0, 1'b0);
    prim_sf(1'b1, 1'b0);
    pa = 16'($urandom);
    prim_sf(1'b0, 1'b1);
    prim_sf(1'b0, 1'b0);
    chk(pp, bp);
    wr(bpms_pkg::OFS_CMD, 16'h0002);
    expq.push_back(8'h81);
    pulse(0);
    wait_q();
    $display("primary test done");
    wr(bpms_pkg::OFS_MAXMISS, 16'h0003);
    wr(bpms_pkg::OFS_CTRL, 16'h0001);
    pa = 16'($urandom);
    sec_sf(1'b1, 16'h0000);
    rdc(bpms_pkg::OFS_PADDR, 16'hffff, pa);
    sec_sf(1'b0, 16'h0000);
    sec_sf(1'b0, 16'h0000);
    rdc(bpms_pkg::OFS_STATUS, 16'hff00, 16'h0200);
    sec_sf(1'b0, 16'h0020);
    rdc(bpms_pkg::OFS_STATUS, 16'h0001, 16'h0001);
    pa = ~pa;
    sec_sf(1'b1, 16'h0000);
    rdc(bpms_pkg::OFS_STATUS, 16'hff00, 16'h0000);
    rdc(bpms_pkg::OFS_PADDR, 16'hffff, pa);
    wr(bpms_pkg::OFS_CTRL, 16'h0011);
    pa = ~pa;
    ans_ack <= 1'b0;
    sec_sf(1'b1, 16'h4008);
    wr(bpms_pkg::OFS_CMD, 16'h0004);
    wr(bpms_pkg::OFS_CTRL, 16'h0001);
    rdc(bpms_pkg::OFS_STATUS, 16'h0002, 16'h0000);
    $display("secondary test done");
    ans_ack <= 1'b0;
    wr(bpms_pkg::OFS_CMD, 16'h0001);
    sec_sf(1'b1, 16'h4008);
    rdc(bpms_pkg::OFS_STATUS, 16'h0002, 16'h0002);
    sec_sf(1'b1, 16'h0000);
    ans_ack <= 1'b1;
    pp = 16'($urandom);
    wr(bpms_pkg::OFS_CMD, 16'h0002);
    sec_sf(1'b1, 16'h0008);
    expq.push_back(8'h81);
    pulse(0);
    wait_q();
    rdc(bpms_pkg::OFS_STATUS, 16'h0004, 16'h0004);
    $display("request test done");
    wr(bpms_pkg::OFS_CTRL, 16'h000d);
    cyc(2);
    chk(pp, bp);
    chk(0, ini);
    rdc(bpms_pkg::OFS_STATUS, 16'h0008, 16'h0008);
    cyc(30);
    chk(1, ini);
    chk(0, 16'(expq.size()));
    $display("promotion test done");
    final_report();
  end
endmodule
